/* File: src/pmx_pin_cell.sv */
// One pin cell: choose plain I/O or alternate drive, registered
`timescale 1ns/1ns
`default_nettype none
module pmx_pin_cell
   import pmx_pkg::*;
(
   input wire logic clock, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic sel, // Alternate function selected
   input wire logic gpio_dout, // Port latch output value
   input wire logic gpio_oe, // Port latch drive enable
   input wire logic alt_dout, // Peripheral output value
   input wire logic alt_oe, // Peripheral drive enable
   output logic pad_out, // Pad output value
   output logic pad_oe // Pad output enable
);
   logic next_pad_out;
   logic next_pad_oe;

   // Alternate path only while selected, else ordinary bidirectional I/O
   always_comb begin
      next_pad_out = sel ? alt_dout : gpio_dout;
      next_pad_oe = sel ? alt_oe : gpio_oe;
   end

   // Reset releases the pad so nothing fights an external driver
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
      end else begin
         pad_out <= next_pad_out;
         pad_oe <= next_pad_oe;
      end
   end
endmodule
`default_nettype wire

/* File: src/pmx_pkg.sv */
// Package for the port alternate function mux: offsets, masks, reset values, carriers
package pmx_pkg;
   // Special function register addresses on the internal register port
   localparam logic [7:0] PMX_ADDR_P1_SELECT = 8'h91;
   localparam logic [7:0] PMX_ADDR_P3_SELECT = 8'h93;
   localparam logic [7:0] PMX_ADDR_P4_SELECT = 8'h94;
   // Implemented bits; reserved bits read zero
   localparam logic [7:0] PMX_P1_MASK = 8'hF0;
   localparam logic [7:0] PMX_P3_MASK = 8'hC0;
   localparam logic [7:0] PMX_P4_MASK = 8'hFF;
   // Reset values: every register-selected pin plain I/O
   localparam logic [7:0] PMX_P1_RESET = 8'h00;
   localparam logic [7:0] PMX_P3_RESET = 8'h00;
   localparam logic [7:0] PMX_P4_RESET = 8'h00;
   // Field positions
   localparam int PMX_P1_ADC_LSB = 4;
   localparam int PMX_P3_SDA_BIT = 6;
   localparam int PMX_P3_SCL_BIT = 7;
   localparam int PMX_P4_PWM_LSB = 3;
   localparam int PMX_P4_VSYNC_BIT = 2;
   localparam int PMX_P4_DISP_SCL_BIT = 1;
   localparam int PMX_P4_DISP_SDA_BIT = 0;

   // One 8-bit port as seen from the pad side
   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe;
   } pmx_pad_drive_t;

   // Register port write request
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pmx_reg_req_t;
endpackage

/* File: src/pmx_port_mux.sv */
// Port alternate function mux: select registers and pin routing for ports 1, 3, 4
//
// Function
// - Ports 0, 2 are bus-only, absent small package
// - Unselected pins act as bidirectional I/O
// - Select bit one hands pin to peripheral
// - Port 1 bits 0-3 steered by peripherals
// - Port 1 pins 0-3 I/O after reset; here they follow p1_periph_sel, which reset leaves alone
// - Port 1 bits 4-7 route ADC inputs
// - Port 3.6/3.7 never carry read/write strobes
// - Ports 3, 4 reset to I/O; port 3 bits 0-5 follow p3_periph_sel, which reset leaves alone
// - Port 3 bits 7, 6 give SCL, SDA
// - Port 3 bits 0-5 steered by peripherals
// - Port 4 bits give PWM, sync, display
// - USB pins are USB lines only
`timescale 1ns/1ns
`default_nettype none
module pmx_port_mux
   import pmx_pkg::*;
(
   input wire logic clock, // System clock, 250 MHz
   input wire logic rst, // Async reset, active high
   input wire pmx_reg_req_t reg_req, // Register write from the CPU core
   input wire logic [7:0] reg_raddr, // Register read address
   output logic [7:0] reg_rdata, // Registered read data
   input wire logic [7:0] p1_gpio_dout, // Port 1 latch value
   input wire logic [7:0] p1_gpio_oe, // Port 1 latch drive enables
   input wire logic [3:0] p1_periph_sel, // Timer 2 / second UART pin claims
   input wire logic [3:0] p1_periph_dout, // Timer 2 / second UART outputs
   input wire logic [3:0] p1_periph_oe, // Timer 2 / second UART enables
   input wire logic [7:0] p1_pad_in, // Port 1 pad levels
   output pmx_pad_drive_t p1_pad, // Port 1 pad drive
   output logic [7:0] p1_pin_level, // Port 1 synchronised pad levels
   output logic [3:0] analog_input_channel, // ADC channel 0..3 connected
   input wire logic [7:0] p3_gpio_dout, // Port 3 latch value
   input wire logic [7:0] p3_gpio_oe, // Port 3 latch drive enables
   input wire logic [5:0] p3_periph_sel, // UART/interrupt/timer pin claims
   input wire logic [5:0] p3_periph_dout, // UART/interrupt/timer outputs
   input wire logic [5:0] p3_periph_oe, // UART/interrupt/timer enables
   input wire logic [7:0] p3_pad_in, // Port 3 pad levels
   output pmx_pad_drive_t p3_pad, // Port 3 pad drive
   output logic [7:0] p3_pin_level, // Port 3 synchronised pad levels
   input wire logic i2c_scl_oe, // I2C unit pulls SCL low
   input wire logic i2c_sda_oe, // I2C unit pulls SDA low
   output logic i2c_scl_in, // SCL level to I2C unit
   output logic i2c_sda_in, // SDA level to I2C unit
   input wire logic [7:0] p4_gpio_dout, // Port 4 latch value
   input wire logic [7:0] p4_gpio_oe, // Port 4 latch drive enables
   input wire logic [4:0] pwm_out, // PWM channels 0..4
   input wire logic vsync_out, // Vertical sync
   input wire logic disp_scl_oe, // Display info channel clock pull-low
   input wire logic disp_sda_oe, // Display info channel data pull-low
   input wire logic [7:0] p4_pad_in, // Port 4 pad levels
   output pmx_pad_drive_t p4_pad, // Port 4 pad drive
   output logic [7:0] p4_pin_level, // Port 4 synchronised pad levels
   output logic disp_scl_in, // Display clock level to its unit
   output logic disp_sda_in // Display data level to its unit
);
   // Ports 0 and 2 have no select and are owned by the bus unit
   // (absent in the small package), so nothing here touches them.
   // USB +/- pins are wired straight to the transceiver outside this
   // block and never enter the mux.
   // Read and write strobes live on dedicated pins; port 3.6/3.7 only
   // ever see I/O or I2C below.

   logic [7:0] port1_function_select;
   logic [7:0] port3_function_select;
   logic [7:0] port4_function_select;
   logic [7:0] next_p1_sel;
   logic [7:0] next_p3_sel;
   logic [7:0] next_p4_sel;

   // Register writes; reserved bits masked so they hold zero
   // Masking on the way in means readback needs no second mask
   always_comb begin
      next_p1_sel = port1_function_select;
      next_p3_sel = port3_function_select;
      next_p4_sel = port4_function_select;
      if (reg_req.wr) begin
         case (reg_req.addr)
            PMX_ADDR_P1_SELECT: next_p1_sel = reg_req.wdata & PMX_P1_MASK;
            PMX_ADDR_P3_SELECT: next_p3_sel = reg_req.wdata & PMX_P3_MASK;
            PMX_ADDR_P4_SELECT: next_p4_sel = reg_req.wdata & PMX_P4_MASK;
            default: ;
         endcase
      end
   end

   // Reset returns every register-selected pin to I/O
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         port1_function_select <= PMX_P1_RESET;
         port3_function_select <= PMX_P3_RESET;
         port4_function_select <= PMX_P4_RESET;
      end else begin
         port1_function_select <= next_p1_sel;
         port3_function_select <= next_p3_sel;
         port4_function_select <= next_p4_sel;
      end
   end

   logic [7:0] next_rdata;

   // Readback; unmapped addresses read zero
   always_comb begin
      case (reg_raddr)
         PMX_ADDR_P1_SELECT: next_rdata = port1_function_select;
         PMX_ADDR_P3_SELECT: next_rdata = port3_function_select;
         PMX_ADDR_P4_SELECT: next_rdata = port4_function_select;
         default: next_rdata = 8'h00;
      endcase
   end

   // Effective per-pin selects and alternate drives
   logic [7:0] p1_sel;
   logic [7:0] p1_alt_dout;
   logic [7:0] p1_alt_oe;
   logic [7:0] p3_sel;
   logic [7:0] p3_alt_dout;
   logic [7:0] p3_alt_oe;
   logic [7:0] p4_sel;
   logic [7:0] p4_alt_dout;
   logic [7:0] p4_alt_oe;

   // Ownership per pin and the drive each alternate source offers
   always_comb begin
      // Port 1 low pins follow their own peripherals' claims
      p1_sel = {port1_function_select[7:PMX_P1_ADC_LSB], p1_periph_sel};
      // ADC pins are inputs: the alternate path never drives them
      p1_alt_dout = {4'h0, p1_periph_dout};
      p1_alt_oe = {4'h0, p1_periph_oe};
      // Port 3 low pins claimed by UART, interrupt, timer config
      p3_sel = {port3_function_select[PMX_P3_SCL_BIT:PMX_P3_SDA_BIT],
                p3_periph_sel};
      // I2C is open drain: drive low while the unit pulls
      p3_alt_dout = {2'b00, p3_periph_dout};
      p3_alt_oe = {i2c_scl_oe, i2c_sda_oe, p3_periph_oe};
      p4_sel = port4_function_select;
      p4_alt_dout = {pwm_out, vsync_out, 2'b00};
      p4_alt_oe = {5'h1F, 1'b1, disp_scl_oe, disp_sda_oe};
   end

   // One registered cell per pin, 24 in all
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pin
         pmx_pin_cell u_p1 (
            .clock(clock), .rst(rst), .sel(p1_sel[gi]),
            .gpio_dout(p1_gpio_dout[gi]), .gpio_oe(p1_gpio_oe[gi]),
            .alt_dout(p1_alt_dout[gi]), .alt_oe(p1_alt_oe[gi]),
            .pad_out(p1_pad.dout[gi]), .pad_oe(p1_pad.oe[gi])
         );
         pmx_pin_cell u_p3 (
            .clock(clock), .rst(rst), .sel(p3_sel[gi]),
            .gpio_dout(p3_gpio_dout[gi]), .gpio_oe(p3_gpio_oe[gi]),
            .alt_dout(p3_alt_dout[gi]), .alt_oe(p3_alt_oe[gi]),
            .pad_out(p3_pad.dout[gi]), .pad_oe(p3_pad.oe[gi])
         );
         pmx_pin_cell u_p4 (
            .clock(clock), .rst(rst), .sel(p4_sel[gi]),
            .gpio_dout(p4_gpio_dout[gi]), .gpio_oe(p4_gpio_oe[gi]),
            .alt_dout(p4_alt_dout[gi]), .alt_oe(p4_alt_oe[gi]),
            .pad_out(p4_pad.dout[gi]), .pad_oe(p4_pad.oe[gi])
         );
      end
   endgenerate

   // Pad inputs are asynchronous: two flops before anyone reads them
   logic [23:0] pad_meta;
   logic [23:0] pad_sync;
   logic [23:0] next_pad_meta;
   logic [3:0] next_analog;
   logic [3:0] next_i2c_disp;
   logic [23:0] next_pad_sync;
   logic [7:0] next_p1_level;
   logic [7:0] next_p3_level;
   logic [7:0] next_p4_level;

   always_comb begin
      next_pad_meta = {p4_pad_in, p3_pad_in, p1_pad_in};
      // Only the second stage reads the first; logic reads the second
      next_pad_sync = pad_meta;
      // Levels lag the pads by three edges: two to settle, one to register
      next_p1_level = pad_sync[7:0];
      next_p3_level = pad_sync[15:8];
      next_p4_level = pad_sync[23:16];
      // ADC channel connect flag follows the select directly
      next_analog = port1_function_select[7:PMX_P1_ADC_LSB];
      // Serial units see the pin only while they own it; idle high otherwise
      next_i2c_disp[0] = port3_function_select[PMX_P3_SCL_BIT] ? pad_sync[15] : 1'b1;
      next_i2c_disp[1] = port3_function_select[PMX_P3_SDA_BIT] ? pad_sync[14] : 1'b1;
      next_i2c_disp[2] = port4_function_select[PMX_P4_DISP_SCL_BIT] ? pad_sync[17] : 1'b1;
      next_i2c_disp[3] = port4_function_select[PMX_P4_DISP_SDA_BIT] ? pad_sync[16] : 1'b1;
   end

   // Input synchroniser and registered outputs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pad_meta <= 24'h000000;
         pad_sync <= 24'h000000;
         reg_rdata <= 8'h00;
         analog_input_channel <= 4'h0;
         i2c_scl_in <= 1'b1;
         i2c_sda_in <= 1'b1;
         disp_scl_in <= 1'b1;
         disp_sda_in <= 1'b1;
         p1_pin_level <= 8'h00;
         p3_pin_level <= 8'h00;
         p4_pin_level <= 8'h00;
      end else begin
         pad_meta <= next_pad_meta;
         pad_sync <= next_pad_sync;
         reg_rdata <= next_rdata;
         analog_input_channel <= next_analog;
         i2c_scl_in <= next_i2c_disp[0];
         i2c_sda_in <= next_i2c_disp[1];
         disp_scl_in <= next_i2c_disp[2];
         disp_sda_in <= next_i2c_disp[3];
         p1_pin_level <= next_p1_level;
         p3_pin_level <= next_p3_level;
         p4_pin_level <= next_p4_level;
      end
   end
endmodule
`default_nettype wire

/* File: verification/pmx_pad_model.sv */
// Pad model: pull-up on every pin, an outside device may pull pins low
`timescale 1ns/1ns
`default_nettype none
module pmx_pad_model
   import pmx_pkg::*;
(
   input wire pmx_pad_drive_t pad, // Drive from the mux
   input wire logic [7:0] ext_low, // Outside device pulls pin low
   output logic [7:0] pad_in // Resolved pin level
);
   // Released pins float up, so a stale driven value never lingers
   assign pad_in = (pad.oe & pad.dout | ~pad.oe) & ~ext_low;
endmodule
`default_nettype wire

/* File: verification/pmx_port_mux_monitor.sv */
// Checker for the port mux: mirrored selects against pads, readback and pin levels
`timescale 1ns/1ns
`default_nettype none
module pmx_port_mux_monitor
   import pmx_pkg::*;
(
   input wire logic clock, // System clock
   input wire logic rst, // Async reset, active high
   input wire pmx_reg_req_t reg_req, // Register write
   input wire logic [7:0] reg_raddr, // Read address
   input wire logic [7:0] reg_rdata, // Readback
   input wire logic [7:0] p1_gpio_oe, // P1 latch enables
   input wire logic [3:0] p1_periph_sel, // P1 peripheral claims
   input wire logic [3:0] p1_periph_oe, // P1 peripheral enables
   input wire pmx_pad_drive_t p1_pad, // P1 pad drive
   input wire logic [3:0] analog_input_channel, // ADC routing
   input wire logic [7:0] p3_gpio_oe, // P3 latch enables
   input wire pmx_pad_drive_t p3_pad, // P3 pad drive
   input wire logic i2c_scl_oe, // I2C clock pull
   input wire logic i2c_sda_oe, // I2C data pull
   input wire logic i2c_scl_in, // I2C clock level
   input wire logic i2c_sda_in, // I2C data level
   input wire logic [7:0] p4_gpio_dout, // P4 latch value
   input wire logic [7:0] p4_gpio_oe, // P4 latch enables
   input wire logic [4:0] pwm_out, // PWM sources
   input wire logic vsync_out, // Sync source
   input wire logic disp_scl_oe, // Display clock pull
   input wire logic disp_sda_oe, // Display data pull
   input wire pmx_pad_drive_t p4_pad, // P4 pad drive
   input wire logic [7:0] p4_pad_in, // P4 pad levels
   input wire logic [7:0] p4_pin_level // P4 synced levels
);
   logic [7:0] s1, s3, s4, rdx, e1o, e4o, e4d;
   logic [1:0] e3o;
   logic [1:0] cnt;
   logic ok;
   // Mirror of the selects; checks other than a_resv wait three edges so sync chains are past reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         {s1, s3, s4} <= 24'h000000;
         cnt <= 2'h0;
      end else begin
         cnt <= ok ? cnt : cnt + 2'h1;
         if (reg_req.wr)
            case (reg_req.addr)
               PMX_ADDR_P1_SELECT: s1 <= reg_req.wdata & PMX_P1_MASK;
               PMX_ADDR_P3_SELECT: s3 <= reg_req.wdata & PMX_P3_MASK;
               PMX_ADDR_P4_SELECT: s4 <= reg_req.wdata;
               default: ;
            endcase
      end
   end
   assign ok = cnt == 2'h3;
   assign rdx = reg_raddr == PMX_ADDR_P1_SELECT ? s1 : reg_raddr == PMX_ADDR_P3_SELECT ? s3 :
      reg_raddr == PMX_ADDR_P4_SELECT ? s4 : 8'h00;
   assign e1o = {~s1[7:4] & p1_gpio_oe[7:4],
      p1_periph_sel & p1_periph_oe | ~p1_periph_sel & p1_gpio_oe[3:0]};
   assign e3o = s3[7:6] & {i2c_scl_oe, i2c_sda_oe} | ~s3[7:6] & p3_gpio_oe[7:6];
   assign e4o = s4 & {6'h3F, disp_scl_oe, disp_sda_oe} | ~s4 & p4_gpio_oe;
   assign e4d = s4 & {pwm_out, vsync_out, 2'b00} | ~s4 & p4_gpio_dout;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_p1; ok |-> p1_pad.oe == $past(e1o); endproperty
   a_p1: assert property (p_p1) else $error("Port 1 drive enable wrong");
   property p_adc; ok |-> analog_input_channel == $past(s1[7:4]); endproperty
   a_adc: assert property (p_adc) else $error("ADC routing differs from select");
   property p_rd; ok |-> reg_rdata == $past(rdx); endproperty
   a_rd: assert property (p_rd) else $error("Select readback wrong");
   property p_resv; reg_raddr == PMX_ADDR_P3_SELECT |=> reg_rdata[5:0] == 6'h00; endproperty
   a_resv: assert property (p_resv) else $error("Reserved bits read nonzero");
   property p_p3; ok |-> p3_pad.oe[7:6] == $past(e3o); endproperty
   a_p3: assert property (p_p3) else $error("Port 3 I2C pins drive wrong");
   property p_idle; ok && $past(s3[7:6]) == 2'b00 |-> i2c_scl_in && i2c_sda_in; endproperty
   a_idle: assert property (p_idle) else $error("I2C input not idle high");
   property p_p4; ok |-> p4_pad.oe == $past(e4o) && p4_pad.dout == $past(e4d); endproperty
   a_p4: assert property (p_p4) else $error("Port 4 drive wrong");
   property p_lvl; ok |-> p4_pin_level == $past(p4_pad_in, 3); endproperty
   a_lvl: assert property (p_lvl) else $error("Port 4 pin level latency wrong");
endmodule
bind pmx_port_mux pmx_port_mux_monitor mon (.*);
`default_nettype wire

/* File: verification/tb_pmx_port_mux.sv */
// Testbench for the port mux: register rows, pin routing and a mid-run reset
`timescale 1ns/1ns
`default_nettype none
module tb_pmx_port_mux
   import pmx_pkg::*;
;
   typedef struct {logic [7:0] a, d, e;} pmx_row_t;
   // Address, write value, expected readback
   pmx_row_t rows [7] = '{'{8'h91, 8'hFF, 8'hF0}, '{8'h93, 8'hFF, 8'hC0}, '{8'h94, 8'hA5, 8'hA5},
      '{8'h92, 8'h77, 8'h00}, '{8'h93, 8'h3F, 8'h00}, '{8'h91, 8'h0F, 8'h00}, '{8'h94, 8'h00, 8'h00}};
   logic clock = 1'b0, rst = 1'b1;
   pmx_reg_req_t reg_req = '0;
   logic [7:0] reg_raddr = 8'h00, reg_rdata, p1_gpio_dout = 8'hFF, p1_gpio_oe = 8'hFF;
   logic [7:0] p3_gpio_dout = 8'hFF, p3_gpio_oe = 8'hFF, p4_gpio_dout = 8'hFF, p4_gpio_oe = 8'h00;
   logic [7:0] p1_pad_in, p3_pad_in, p4_pad_in, p1_pin_level, p3_pin_level, p4_pin_level;
   logic [7:0] ext3 = 8'h00;
   logic [3:0] p1_periph_sel = 4'h0, p1_periph_dout = 4'h0, p1_periph_oe = 4'h0;
   logic [3:0] analog_input_channel;
   logic [5:0] p3_periph_sel = 6'h00, p3_periph_dout = 6'h00, p3_periph_oe = 6'h00;
   logic [4:0] pwm_out = 5'h00;
   logic vsync_out = 1'b0, i2c_scl_oe = 1'b0, i2c_sda_oe = 1'b0;
   logic disp_scl_oe = 1'b0, disp_sda_oe = 1'b0;
   logic i2c_scl_in, i2c_sda_in, disp_scl_in, disp_sda_in;
   pmx_pad_drive_t p1_pad, p3_pad, p4_pad;
   int err_count = 0, comparisons = 0, cyc = 0;
   pmx_port_mux dut (.*);
   pmx_pad_model m1 (.pad(p1_pad), .ext_low(8'h00), .pad_in(p1_pad_in));
   pmx_pad_model m3 (.pad(p3_pad), .ext_low(ext3), .pad_in(p3_pad_in));
   pmx_pad_model m4 (.pad(p4_pad), .ext_low(8'h00), .pad_in(p4_pad_in));
   initial forever #2 clock = ~clock;
   task automatic give_verdict();
      if (err_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Guards against a hung run; the run needs under a hundred cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      chk8(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_req <= '{1'b1, a, d};
      @(posedge clock);
      reg_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_raddr <= a;
      tick(2);
      chk8("rdata", e, reg_rdata);
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      // Port 4 all alternates, display clock pulled low
      @(posedge clock);
      pwm_out <= 5'h15;
      vsync_out <= 1'b1;
      disp_scl_oe <= 1'b1;
      wr(PMX_ADDR_P4_SELECT, 8'hFF);
      tick(2);
      chk8("p4_oe", 8'hFE, p4_pad.oe);
      chk8("p4_dout", 8'hAC, p4_pad.dout);
      tick(5);
      chk1("disp_scl_in", 1'b0, disp_scl_in);
      chk1("disp_sda_in", 1'b1, disp_sda_in);
      // Port 3: I2C on top pins, peripherals claim the rest, outside device holds SDA
      @(posedge clock);
      i2c_scl_oe <= 1'b1;
      p3_periph_sel <= 6'h3F;
      p3_periph_oe <= 6'h15;
      p3_periph_dout <= 6'h2A;
      ext3 <= 8'h40;
      wr(PMX_ADDR_P3_SELECT, 8'hC0);
      tick(2);
      chk8("p3_oe", 8'h95, p3_pad.oe);
      chk8("p3_dout", 8'h2A, p3_pad.dout);
      tick(5);
      chk1("i2c_scl_in", 1'b0, i2c_scl_in);
      chk1("i2c_sda_in", 1'b0, i2c_sda_in);
      chk8("p3_level", 8'h2A, p3_pin_level);
      // Port 1: ADC pins released, timer pins taken by peripheral claim
      @(posedge clock);
      p1_periph_sel <= 4'h3;
      p1_periph_oe <= 4'h1;
      p1_periph_dout <= 4'h2;
      wr(PMX_ADDR_P1_SELECT, 8'hF0);
      tick(2);
      chk8("p1_oe", 8'h0D, p1_pad.oe);
      chk8("p1_dout", 8'hFE, p1_pad.dout | 8'hF0);
      chk8("adc", 8'h0F, {4'h0, analog_input_channel});
      tick(3);
      chk8("p1_level", 8'hFE, p1_pin_level);
      // Deselect port 4: pins fall back to the latch
      @(posedge clock);
      p4_gpio_oe <= 8'h5A;
      p1_periph_sel <= 4'h0;
      wr(PMX_ADDR_P4_SELECT, 8'h00);
      tick(2);
      chk8("p4_gpio_oe", 8'h5A, p4_pad.oe);
      @(posedge clock);
      rst <= 1'b1;
      tick(2);
      chk8("rst_oe", 8'h00, p4_pad.oe);
      @(posedge clock);
      rst <= 1'b0;
      rd(PMX_ADDR_P1_SELECT, 8'h00);
      rd(PMX_ADDR_P3_SELECT, 8'h00);
      rd(PMX_ADDR_P4_SELECT, 8'h00);
      chk8("p1_oe_rst", 8'hFF, p1_pad.oe);
      give_verdict();
   end
endmodule
`default_nettype wire
